// file: hw/rtcf_pkg.sv
package rtcf_pkg;

	// ********************************
	// clock and time-outs
	// ********************************
	localparam int RTCF_CLK_HZ     = 125_000_000;
	localparam int RTCF_POWER_UP_TIMER_MS    = 72;
	localparam int RTCF_PLL_MS     = 2;
	localparam int RTCF_OST_TOSC   = 1024;
	localparam int RTCF_POWER_UP_TIMER_CYC   = RTCF_POWER_UP_TIMER_MS * (RTCF_CLK_HZ / 1000);
	localparam int RTCF_PLL_CYC    = RTCF_PLL_MS * (RTCF_CLK_HZ / 1000);
	localparam int RTCF_OST_CYC    = RTCF_OST_TOSC;
	localparam int RTCF_CNT_W      = 24;

	// ********************************
	// register map
	// ********************************
	localparam logic [1:0] RTCF_OFS_RESET_CAUSE_CONTROL  = 2'h0;
	localparam logic [1:0] RTCF_OFS_STACK = 2'h1;
	localparam logic [1:0] RTCF_OFS_SEQ   = 2'h2;

	localparam int RTCF_B_INTERRUPT_PRIORITY_ENABLE = 7;
	localparam int RTCF_B_RI   = 4;
	localparam int RTCF_B_TO   = 3;
	localparam int RTCF_B_PD   = 2;
	localparam int RTCF_B_POR  = 1;
	localparam int RTCF_B_BOR  = 0;
	localparam int RTCF_B_OVF  = 1;
	localparam int RTCF_B_UNF  = 0;

	localparam logic [7:0] RTCF_RESET_CAUSE_CONTROL_RST   = 8'h9D & 8'h1F;
	localparam logic [7:0] RTCF_RESET_CAUSE_CONTROL_WMASK = 8'h9F;
	localparam logic [1:0] RTCF_STACK_RST  = 2'h0;

	// ********************************
	// program counter values
	// ********************************
	localparam int         RTCF_PC_W   = 21;
	localparam int         RTCF_SP_W   = 5;
	localparam logic [20:0] RTCF_PC_RST = 21'h000000;
	localparam logic [20:0] RTCF_VEC_HI = 21'h000008;
	localparam logic [20:0] RTCF_VEC_LO = 21'h000018;
	localparam logic [20:0] RTCF_PC_STEP = 21'h000002;
	localparam logic [4:0]  RTCF_SP_STEP = 5'h01;

	localparam int RTCF_CAN_COPIES = 5;

	// ********************************
	// modes and states
	// ********************************
	typedef enum logic [2:0] {
		RTCF_OSC_LP   = 3'h0,
		RTCF_OSC_XT   = 3'h1,
		RTCF_OSC_HS   = 3'h2,
		RTCF_OSC_EC   = 3'h3,
		RTCF_OSC_EXT_CLOCK_WITH_IO_MODE = 3'h4,
		RTCF_OSC_RC   = 3'h5,
		RTCF_OSC_RESISTOR_CAP_WITH_IO_MODE = 3'h6
	} rtcf_osc_e;

	typedef enum logic [5:0] {
		RTCF_ST_DET  = 6'h01,
		RTCF_ST_POWER_UP_TIMER = 6'h02,
		RTCF_ST_OST  = 6'h04,
		RTCF_ST_PLL  = 6'h08,
		RTCF_ST_MASTER_CLEAR_PIN = 6'h10,
		RTCF_ST_RUN  = 6'h20
	} rtcf_st_e;

endpackage

// file: hw/rtcf_top.sv
// Notes on behaviour
// - power-on delay, then power-up timer, then start-up timer
// - RC mode, timer disabled: no time-out except after brown-out
// - time-outs run from power-on; pin release starts
// - power-up timer 72 ms, enabled or brown-out
// - crystal modes wait 1024 periods, PLL adds 2 ms in HS only
// - HS with PLL adds 2 ms lock wait
// - wake or switch: start-up and PLL only
// - cause register 8 bits, bits 6:5 unused
// - power-on: PC 0, flags 11100, stack kept
// - brown-out: PC 0, flags 111u0
// - pin reset in run: PC 0, flags kept
// - reset instruction: PC 0, clear its flag
// - overflow reset: PC 0, overflow flag set
// - underrun reset: PC 0, underrun flag set
// - sleep pin, watchdog reset, watchdog wake flags
// - interrupt wake: PC+2 or vector 08h/18h
// - vectored wake pushes PC, bumps pointer
// - every reset sets all directions input
// - port A bit 6 only in IO modes
// - CAN status reset reaches every mirror copy
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module rtcf_top
	import rtcf_pkg::*;
#(
	parameter int POWER_UP_TIMER_CYC = RTCF_POWER_UP_TIMER_CYC,
	parameter int PLL_CYC  = RTCF_PLL_CYC,
	parameter int OST_CYC  = RTCF_OST_CYC
) (
	// clock, reset, enable
	input  wire logic                 CLK_SYS,
	input  wire logic                 RST_B,
	input  wire logic                 CE,
	// detectors and pin
	input  wire logic                 POR_DETECT,
	input  wire logic                 BOR_DETECT,
	input  wire logic                 MASTER_CLEAR_PIN_B,
	// core events
	input  wire logic                 SLEEP_ACTIVE,
	input  wire logic                 WATCHDOG_EXPIRE,
	input  wire logic                 IRQ_WAKE,
	input  wire logic                 IRQ_HIGH_PRIO,
	input  wire logic                 RESET_INSTR,
	input  wire logic                 STACK_OVERFLOW,
	input  wire logic                 STACK_UNDERRUN,
	input  wire logic                 OSC_SWITCH,
	// configuration
	input  wire logic [2:0]           OSC_MODE,
	input  wire logic                 PLL_ENABLE,
	input  wire logic                 POWER_UP_TIMER_DISABLE_CFG,
	input  wire logic                 HIGH_PRIO_GLOBAL_IRQ_ENABLE,
	input  wire logic                 LOW_PRIO_GLOBAL_IRQ_ENABLE,
	// core state
	input  wire logic [RTCF_PC_W-1:0] PC_CURRENT,
	input  wire logic [RTCF_SP_W-1:0] STACK_POINTER_CUR,
	// register port
	input  wire logic [1:0]           REG_ADDR,
	input  wire logic [7:0]           REG_WDATA,
	input  wire logic                 REG_WR,
	input  wire logic                 REG_RD,
	output logic      [7:0]           REG_RDATA,
	// core control
	output logic                      CORE_RESET,
	output logic                      CORE_HOLD,
	output logic                      PC_LOAD,
	output logic      [RTCF_PC_W-1:0] PC_VALUE,
	output logic                      TOS_WRITE,
	output logic      [4:0]           TOP_OF_STACK_UPPER,
	output logic      [7:0]           TOP_OF_STACK_HIGH,
	output logic      [7:0]           TOP_OF_STACK_LOW,
	output logic                      STACK_POINTER_WRITE,
	output logic      [RTCF_SP_W-1:0] STACK_POINTER_NEXT,
	// reset side effects
	output logic                      DIRECTION_SET_ALL,
	output logic                      PORT_A_BIT6_EN,
	output logic [RTCF_CAN_COPIES-1:0] CAN_STATUS_RESET,
	output logic                      INTERRUPT_PRIORITY_ENABLE
);

	// ********************************
	// checks and state
	// ********************************
	if (POWER_UP_TIMER_CYC < 1 || POWER_UP_TIMER_CYC >= (1 << RTCF_CNT_W) ||
	    PLL_CYC < 1 || PLL_CYC >= (1 << RTCF_CNT_W) ||
	    OST_CYC < 1 || OST_CYC >= (1 << RTCF_CNT_W)) begin : g_bad
		$error("rtcf_top: time-out count out of range");
	end

	typedef struct packed {
		logic                  por_s1;
		logic                  por_s2;
		logic                  bor_s1;
		logic                  bor_s2;
		logic                  master_clear_pin_s1;
		logic                  master_clear_pin_s2;
		rtcf_st_e              st;
		logic [RTCF_CNT_W-1:0] cnt;
		logic                  wake;
		logic                  bor_seq;
		logic [7:0]            reset_cause_control;
		logic [1:0]            stk;
		logic                  pc_load;
		logic [RTCF_PC_W-1:0]  pc;
		logic                  tos_we;
		logic [RTCF_PC_W-1:0]  tos;
		logic                  sp_we;
		logic [RTCF_SP_W-1:0]  sp;
		logic                  tris_set;
		logic [7:0]            rdata;
	} rtcf_state_s;

	localparam rtcf_state_s RST_Q = '{
		st: RTCF_ST_DET, reset_cause_control: RTCF_RESET_CAUSE_CONTROL_RST, stk: RTCF_STACK_RST,
		pc: RTCF_PC_RST, default: '0};

	rtcf_state_s q;
	rtcf_state_s next_q;
	logic        xtal;
	logic        pll_on;
	logic        need_power_up_timer;
	rtcf_st_e    fin;
	rtcf_st_e    s;

	// ********************************
	// time-out chain
	// ********************************
	// first applicable stage after cur, else dst
	function automatic rtcf_st_e step(rtcf_st_e cur, logic pw,
		logic xt, logic pl, rtcf_st_e dst);
		rtcf_st_e r;
		r = dst;
		if (cur == RTCF_ST_DET && pw)
			r = RTCF_ST_POWER_UP_TIMER;
		else if ((cur == RTCF_ST_DET || cur == RTCF_ST_POWER_UP_TIMER) && xt)
			r = RTCF_ST_OST;
		else if (cur != RTCF_ST_PLL && pl)
			r = RTCF_ST_PLL;
		return r;
	endfunction

	function automatic logic [RTCF_CNT_W-1:0] load(rtcf_st_e st);
		logic [RTCF_CNT_W-1:0] r;
		case (st)
			RTCF_ST_POWER_UP_TIMER: r = RTCF_CNT_W'(POWER_UP_TIMER_CYC - 1);
			RTCF_ST_OST:  r = RTCF_CNT_W'(OST_CYC - 1);
			RTCF_ST_PLL:  r = RTCF_CNT_W'(PLL_CYC - 1);
			default:      r = '0;
		endcase
		return r;
	endfunction

	always_comb begin
		xtal = OSC_MODE == RTCF_OSC_HS || OSC_MODE == RTCF_OSC_XT ||
		       OSC_MODE == RTCF_OSC_LP;
		pll_on = PLL_ENABLE && OSC_MODE == RTCF_OSC_HS;
		need_power_up_timer = q.bor_seq || !POWER_UP_TIMER_DISABLE_CFG;
		fin = q.wake ? RTCF_ST_RUN : RTCF_ST_MASTER_CLEAR_PIN;
		s = step(q.st, need_power_up_timer, xtal, pll_on, fin);
	end

	// ********************************
	// next state
	// ********************************
	always_comb begin
		next_q = q;
		next_q.por_s1 = POR_DETECT;
		next_q.por_s2 = q.por_s1;
		next_q.bor_s1 = BOR_DETECT;
		next_q.bor_s2 = q.bor_s1;
		next_q.master_clear_pin_s1 = MASTER_CLEAR_PIN_B;
		next_q.master_clear_pin_s2 = q.master_clear_pin_s1;
		next_q.pc_load = 1'b0;
		next_q.tos_we = 1'b0;
		next_q.sp_we = 1'b0;
		next_q.tris_set = 1'b0;
		next_q.rdata = 8'h00;
		if (REG_RD) begin
			case (REG_ADDR)
				RTCF_OFS_RESET_CAUSE_CONTROL:  next_q.rdata = q.reset_cause_control;
				RTCF_OFS_STACK: next_q.rdata = {6'h00, q.stk};
				RTCF_OFS_SEQ:   next_q.rdata = {q.wake, 1'b0, q.st};
				default:        next_q.rdata = 8'h00;
			endcase
		end
		if (REG_WR && REG_ADDR == RTCF_OFS_RESET_CAUSE_CONTROL)
			next_q.reset_cause_control = REG_WDATA & RTCF_RESET_CAUSE_CONTROL_WMASK;
		if (REG_WR && REG_ADDR == RTCF_OFS_STACK)
			next_q.stk = REG_WDATA[1:0];
		// hardware events below override a write
		if (q.por_s2) begin
			next_q.st = RTCF_ST_DET;
			next_q.reset_cause_control[4:0] = 5'h1C;
			next_q.bor_seq = 1'b0;
			next_q.wake = 1'b0;
			next_q.pc = RTCF_PC_RST;
			next_q.pc_load = 1'b1;
			next_q.tris_set = 1'b1;
		end else if (q.bor_s2) begin
			next_q.st = RTCF_ST_DET;
			next_q.reset_cause_control[RTCF_B_RI] = 1'b1;
			next_q.reset_cause_control[RTCF_B_TO] = 1'b1;
			next_q.reset_cause_control[RTCF_B_PD] = 1'b1;
			next_q.reset_cause_control[RTCF_B_BOR] = 1'b0;
			next_q.bor_seq = 1'b1;
			next_q.wake = 1'b0;
			next_q.pc = RTCF_PC_RST;
			next_q.pc_load = 1'b1;
			next_q.tris_set = 1'b1;
		end else begin
			case (q.st)
				RTCF_ST_DET: begin
					next_q.st = s;
					next_q.cnt = load(s);
				end
				RTCF_ST_POWER_UP_TIMER, RTCF_ST_OST, RTCF_ST_PLL: begin
					if (q.cnt == '0) begin
						next_q.st = s;
						next_q.cnt = load(s);
						if (s == RTCF_ST_RUN)
							next_q.wake = 1'b0;
					end else begin
						next_q.cnt = q.cnt - 1'b1;
					end
				end
				RTCF_ST_MASTER_CLEAR_PIN: begin
					if (q.master_clear_pin_s2) begin
						next_q.st = RTCF_ST_RUN;
						next_q.bor_seq = 1'b0;
					end
				end
				RTCF_ST_RUN: begin
					// wake flag only lives through a wait
					next_q.wake = 1'b0;
					if (!q.master_clear_pin_s2) begin
						next_q.st = RTCF_ST_MASTER_CLEAR_PIN;
						next_q.pc = RTCF_PC_RST;
						next_q.pc_load = 1'b1;
						next_q.tris_set = 1'b1;
						if (SLEEP_ACTIVE) begin
							next_q.reset_cause_control[RTCF_B_TO] = 1'b1;
							next_q.reset_cause_control[RTCF_B_PD] = 1'b0;
						end
					end else if (WATCHDOG_EXPIRE && SLEEP_ACTIVE) begin
						next_q.reset_cause_control[RTCF_B_TO] = 1'b0;
						next_q.reset_cause_control[RTCF_B_PD] = 1'b0;
						next_q.pc = PC_CURRENT + RTCF_PC_STEP;
						next_q.pc_load = 1'b1;
						next_q.wake = 1'b1;
						next_q.st = step(RTCF_ST_DET, 1'b0, xtal, pll_on,
							RTCF_ST_RUN);
						next_q.cnt = load(next_q.st);
					end else if (WATCHDOG_EXPIRE) begin
						next_q.reset_cause_control[RTCF_B_TO] = 1'b0;
						next_q.reset_cause_control[RTCF_B_PD] = 1'b1;
						next_q.st = RTCF_ST_MASTER_CLEAR_PIN;
						next_q.pc = RTCF_PC_RST;
						next_q.pc_load = 1'b1;
						next_q.tris_set = 1'b1;
					end else if (IRQ_WAKE && SLEEP_ACTIVE) begin
						next_q.reset_cause_control[RTCF_B_TO] = 1'b1;
						next_q.reset_cause_control[RTCF_B_PD] = 1'b0;
						next_q.pc_load = 1'b1;
						next_q.pc = PC_CURRENT + RTCF_PC_STEP;
						if (HIGH_PRIO_GLOBAL_IRQ_ENABLE ||
						    LOW_PRIO_GLOBAL_IRQ_ENABLE) begin
							next_q.pc = IRQ_HIGH_PRIO ? RTCF_VEC_HI
								: RTCF_VEC_LO;
							next_q.tos = PC_CURRENT;
							next_q.tos_we = 1'b1;
							next_q.sp = STACK_POINTER_CUR + RTCF_SP_STEP;
							next_q.sp_we = 1'b1;
						end
						next_q.wake = 1'b1;
						next_q.st = step(RTCF_ST_DET, 1'b0, xtal, pll_on,
							RTCF_ST_RUN);
						next_q.cnt = load(next_q.st);
					end else if (STACK_OVERFLOW) begin
						next_q.stk[RTCF_B_OVF] = 1'b1;
						next_q.st = RTCF_ST_MASTER_CLEAR_PIN;
						next_q.pc = RTCF_PC_RST;
						next_q.pc_load = 1'b1;
						next_q.tris_set = 1'b1;
					end else if (STACK_UNDERRUN) begin
						next_q.stk[RTCF_B_UNF] = 1'b1;
						next_q.st = RTCF_ST_MASTER_CLEAR_PIN;
						next_q.pc = RTCF_PC_RST;
						next_q.pc_load = 1'b1;
						next_q.tris_set = 1'b1;
					end else if (RESET_INSTR) begin
						next_q.reset_cause_control[RTCF_B_RI] = 1'b0;
						next_q.st = RTCF_ST_MASTER_CLEAR_PIN;
						next_q.pc = RTCF_PC_RST;
						next_q.pc_load = 1'b1;
						next_q.tris_set = 1'b1;
					end else if (OSC_SWITCH) begin
						next_q.wake = 1'b1;
						next_q.st = step(RTCF_ST_DET, 1'b0, xtal, pll_on,
							RTCF_ST_RUN);
						next_q.cnt = load(next_q.st);
					end
				end
				default: next_q.st = RTCF_ST_DET;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B)
			q <= RST_Q;
		else if (CE)
			q <= next_q;
	end

	// ********************************
	// outputs
	// ********************************
	assign REG_RDATA = q.rdata;
	assign CORE_HOLD = q.st != RTCF_ST_RUN;
	assign CORE_RESET = q.st != RTCF_ST_RUN && !q.wake;
	assign PC_LOAD = q.pc_load;
	assign PC_VALUE = q.pc;
	assign TOS_WRITE = q.tos_we;
	assign TOP_OF_STACK_UPPER = q.tos[20:16];
	assign TOP_OF_STACK_HIGH = q.tos[15:8];
	assign TOP_OF_STACK_LOW = q.tos[7:0];
	assign STACK_POINTER_WRITE = q.sp_we;
	assign STACK_POINTER_NEXT = q.sp;
	assign DIRECTION_SET_ALL = q.tris_set;
	assign PORT_A_BIT6_EN = OSC_MODE == RTCF_OSC_EXT_CLOCK_WITH_IO_MODE ||
		OSC_MODE == RTCF_OSC_RESISTOR_CAP_WITH_IO_MODE;
	assign CAN_STATUS_RESET = {RTCF_CAN_COPIES{q.tris_set}};
	assign INTERRUPT_PRIORITY_ENABLE = q.reset_cause_control[RTCF_B_INTERRUPT_PRIORITY_ENABLE];

	// ********************************
	// assertions
	// ********************************
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);

	a_power_up_timer_then_ost: assert property (CE && q.st == RTCF_ST_POWER_UP_TIMER &&
		q.cnt == '0 && !q.por_s2 && !q.bor_s2 && xtal
		|=> q.st == RTCF_ST_OST) else $error("ost not after power_up_timer");
	a_rc_no_wait: assert property (CE && q.st == RTCF_ST_DET &&
		!q.por_s2 && !q.bor_s2 && !need_power_up_timer && !xtal
		|=> q.st == RTCF_ST_MASTER_CLEAR_PIN) else $error("rc mode waited");
	a_pin_release: assert property (CE && q.st == RTCF_ST_MASTER_CLEAR_PIN &&
		q.master_clear_pin_s2 && !q.por_s2 && !q.bor_s2 |=> !CORE_RESET)
		else $error("no start on pin release");
	a_power_up_timer_load: assert property (q.st != RTCF_ST_POWER_UP_TIMER ##1
		q.st == RTCF_ST_POWER_UP_TIMER |-> q.cnt == RTCF_CNT_W'(POWER_UP_TIMER_CYC - 1))
		else $error("power_up_timer length wrong");
	a_ost_load: assert property (q.st != RTCF_ST_OST ##1
		q.st == RTCF_ST_OST |-> q.cnt == RTCF_CNT_W'(OST_CYC - 1))
		else $error("ost length wrong");
	a_pll_after_ost: assert property (CE && q.st == RTCF_ST_OST &&
		q.cnt == '0 && pll_on && !q.por_s2 && !q.bor_s2
		|=> q.st == RTCF_ST_PLL) else $error("pll wait skipped");
	a_wake_no_power_up_timer: assert property (q.wake |->
		q.st != RTCF_ST_POWER_UP_TIMER) else $error("power_up_timer on wake");
	a_reset_cause_control_unused: assert property (q.reset_cause_control[6:5] == 2'b00)
		else $error("unused cause bits set");
	a_por_flags: assert property (CE && q.por_s2 |=>
		q.reset_cause_control[4:0] == 5'h1C && q.pc == RTCF_PC_RST)
		else $error("power-on flags wrong");
	a_irq_push: assert property (TOS_WRITE |->
		STACK_POINTER_WRITE && PC_LOAD &&
		(PC_VALUE == RTCF_VEC_HI || PC_VALUE == RTCF_VEC_LO))
		else $error("vectored wake incomplete");
	a_dir_reset: assert property (DIRECTION_SET_ALL |->
		PC_LOAD && PC_VALUE == RTCF_PC_RST && !q.wake)
		else $error("direction reset without reset");

	c_wake: cover property (q.wake ##1 q.st == RTCF_ST_RUN);
	c_pll: cover property (q.st == RTCF_ST_PLL);
	c_stack: cover property (CE && q.st == RTCF_ST_RUN && STACK_OVERFLOW);

endmodule // rtcf_top

// file: sim/rtcf_supply_model.sv
`timescale 1ns/1ns
module rtcf_supply_model (
	// clock
	input  wire logic CLK_SYS,
	// detectors and pin
	output logic      POR_DETECT,
	output logic      BOR_DETECT,
	output logic      MASTER_CLEAR_PIN_B
);
	initial begin
		POR_DETECT = 1'b0;
		BOR_DETECT = 1'b0;
		MASTER_CLEAR_PIN_B = 1'b1;
	end
	// detector high for len cycles
	task automatic supply_dip(input bit brown, input int len);
		@(posedge CLK_SYS);
		if (brown)
			BOR_DETECT <= 1'b1;
		else
			POR_DETECT <= 1'b1;
		repeat (len) @(posedge CLK_SYS);
		POR_DETECT <= 1'b0;
		BOR_DETECT <= 1'b0;
	endtask
	// pin pulled up when released
	task automatic drive_pin(input bit level);
		@(posedge CLK_SYS);
		MASTER_CLEAR_PIN_B <= level;
	endtask
endmodule // rtcf_supply_model

// file: sim/tb_rtcf_top.sv
`timescale 1ns/1ns
module tb_rtcf_top
	import rtcf_pkg::*;
;
	localparam int PW = 20;
	localparam int PL = 10;
	localparam int OS = 8;
	logic        clk, rst_b, sleep, hi_prio, pll, pdis, high_prio_global_irq_enable, low_prio_global_irq_enable, rd, wr;
	logic [5:0]  ev;
	logic [2:0]  mode;
	logic [1:0]  addr;
	logic [7:0]  wdata, d;
	logic [20:0] pc_cur, last_pc, tos_v;
	logic [4:0]  sp_cur, sp_v;
	int          bad_count, cmp_count, dir_cnt, cyc, n, n0, m2, k;
	wire         por, bor, pin_b, c_rst, c_hold, pc_ld, tos_wr, sp_wr;
	wire         dir_all, bit6, ipe;
	wire [7:0]   rdata, top_of_stack_high, top_of_stack_low;
	wire [20:0]  pc_val;
	wire [4:0]   top_of_stack_upper, sp_nx, can;

	rtcf_supply_model i_rtcf_supply_model (.CLK_SYS(clk), .POR_DETECT(por),
		.BOR_DETECT(bor), .MASTER_CLEAR_PIN_B(pin_b));
	rtcf_top #(.POWER_UP_TIMER_CYC(PW), .PLL_CYC(PL), .OST_CYC(OS)) i_rtcf_top (
		.CLK_SYS(clk), .RST_B(rst_b), .CE(1'b1), .POR_DETECT(por),
		.BOR_DETECT(bor), .MASTER_CLEAR_PIN_B(pin_b), .SLEEP_ACTIVE(sleep),
		.WATCHDOG_EXPIRE(ev[0]), .IRQ_WAKE(ev[1]), .IRQ_HIGH_PRIO(hi_prio),
		.RESET_INSTR(ev[2]), .STACK_OVERFLOW(ev[3]), .STACK_UNDERRUN(ev[4]),
		.OSC_SWITCH(ev[5]), .OSC_MODE(mode), .PLL_ENABLE(pll),
		.POWER_UP_TIMER_DISABLE_CFG(pdis),
		.HIGH_PRIO_GLOBAL_IRQ_ENABLE(high_prio_global_irq_enable), .LOW_PRIO_GLOBAL_IRQ_ENABLE(low_prio_global_irq_enable),
		.PC_CURRENT(pc_cur), .STACK_POINTER_CUR(sp_cur), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.CORE_RESET(c_rst), .CORE_HOLD(c_hold), .PC_LOAD(pc_ld),
		.PC_VALUE(pc_val), .TOS_WRITE(tos_wr), .TOP_OF_STACK_UPPER(top_of_stack_upper),
		.TOP_OF_STACK_HIGH(top_of_stack_high), .TOP_OF_STACK_LOW(top_of_stack_low),
		.STACK_POINTER_WRITE(sp_wr), .STACK_POINTER_NEXT(sp_nx),
		.DIRECTION_SET_ALL(dir_all), .PORT_A_BIT6_EN(bit6),
		.CAN_STATUS_RESET(can), .INTERRUPT_PRIORITY_ENABLE(ipe));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ****
	// tasks
	// ****
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask
	// cycles until reset (w=1) or hold (w=0) drops
	task automatic count_high(input bit w, output int c);
		c = 0;
		#1;
		while (c < 1000 && (w ? c_rst : c_hold) !== 1'b0) begin
			@(posedge clk);
			#1;
			c++;
		end
		if (c == 1000)
			check(c, 0);
	endtask
	task automatic power_up(input bit b, input logic [2:0] m, input bit p,
		input bit dis, output int c);
		mode <= m;
		pll <= p;
		pdis <= dis;
		i_rtcf_supply_model.supply_dip(b, 4);
		count_high(1, c);
	endtask
	// event 6 is the pin
	task automatic fire(input int b, output int c);
		if (b == 6) begin
			i_rtcf_supply_model.drive_pin(1'b0);
			repeat (3) @(posedge clk);
			i_rtcf_supply_model.drive_pin(1'b1);
		end else begin
			@(posedge clk);
			ev <= 6'h01 << b;
			@(posedge clk);
			ev <= 6'h00;
		end
		count_high(0, c);
	endtask
	task automatic evt(input int b, input logic [7:0] pre, post,
		input logic [20:0] pc, input bit dir);
		reg_wr(RTCF_OFS_RESET_CAUSE_CONTROL, pre);
		k = dir_cnt;
		last_pc = 21'h1FFFFF;
		fire(b, n);
		reg_rd(RTCF_OFS_RESET_CAUSE_CONTROL, d);
		check(d & 8'h1F, post);
		check(last_pc, pc);
		check(dir_cnt != k, dir);
	endtask

	// ****
	// monitor
	// ****
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (pc_ld === 1'b1)
			last_pc <= pc_val;
		if (tos_wr === 1'b1)
			tos_v <= {top_of_stack_upper, top_of_stack_high, top_of_stack_low};
		if (sp_wr === 1'b1)
			sp_v <= sp_nx;
		if (dir_all === 1'b1)
			dir_cnt <= dir_cnt + 1;
		if (dir_all === 1'b1 || can !== 5'h00)
			check(can, {5{dir_all}});
		if (cyc == 20000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	// ****
	// tests
	// ****
	initial begin
		{rst_b, sleep, hi_prio, pll, high_prio_global_irq_enable, low_prio_global_irq_enable, rd, wr} = 8'h00;
		{ev, addr, wdata} = 16'h0000;
		mode = RTCF_OSC_RC;
		pdis = 1'b1;
		pc_cur = 21'h012344;
		sp_cur = 5'h03;
		{dir_cnt, cyc, bad_count, cmp_count} = 128'h0;
		{last_pc, tos_v, sp_v} = 47'h0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		reg_rd(RTCF_OFS_RESET_CAUSE_CONTROL, d);
		check(d, 8'h1D);
		reg_wr(RTCF_OFS_RESET_CAUSE_CONTROL, 8'hFF);
		reg_rd(RTCF_OFS_RESET_CAUSE_CONTROL, d);
		check(d, 8'h9F);
		check(ipe, 1'b1);
		reg_rd(2'h3, d);
		check(d, 8'h00);
		count_high(1, n);
		power_up(0, RTCF_OSC_RC, 0, 1, n0);
		check(n0 <= 8, 1);
		reg_rd(RTCF_OFS_RESET_CAUSE_CONTROL, d);
		check(d & 8'h1F, 8'h1C);
		check(last_pc, RTCF_PC_RST);
		power_up(0, RTCF_OSC_HS, 1, 0, n);
		check(n - n0, PW + OS + PL);
		power_up(0, RTCF_OSC_XT, 0, 1, n);
		check(n - n0, OS);
		power_up(0, RTCF_OSC_EC, 0, 0, n);
		check(n - n0, PW);
		reg_wr(RTCF_OFS_RESET_CAUSE_CONTROL, 8'h02);
		k = dir_cnt;
		power_up(1, RTCF_OSC_HS, 0, 1, n);
		check(n - n0, PW + OS);
		reg_rd(RTCF_OFS_RESET_CAUSE_CONTROL, d);
		check(d & 8'h1F, 8'h1E);
		check(dir_cnt != k, 1);
		i_rtcf_supply_model.drive_pin(1'b0);
		mode <= RTCF_OSC_XT;
		pdis <= 1'b0;
		i_rtcf_supply_model.supply_dip(0, 4);
		repeat (PW + OS + 20) @(posedge clk);
		#1;
		check(c_rst, 1'b1);
		i_rtcf_supply_model.drive_pin(1'b1);
		count_high(1, n);
		check(n <= 5, 1);
		evt(2, 8'h1F, 8'h0F, RTCF_PC_RST, 1);
		evt(6, 8'h15, 8'h15, RTCF_PC_RST, 1);
		evt(0, 8'h18, 8'h14, RTCF_PC_RST, 1);
		reg_wr(RTCF_OFS_STACK, 8'h00);
		evt(3, 8'h0A, 8'h0A, RTCF_PC_RST, 1);
		reg_rd(RTCF_OFS_STACK, d);
		check(d, 8'h02);
		reg_wr(RTCF_OFS_STACK, 8'h00);
		evt(4, 8'h0A, 8'h0A, RTCF_PC_RST, 1);
		reg_rd(RTCF_OFS_STACK, d);
		check(d, 8'h01);
		sleep <= 1'b1;
		evt(0, 8'h1C, 8'h10, pc_cur + 21'h2, 0);
		evt(6, 8'h10, 8'h18, RTCF_PC_RST, 1);
		evt(1, 8'h14, 8'h18, pc_cur + 21'h2, 0);
		high_prio_global_irq_enable <= 1'b1;
		hi_prio <= 1'b1;
		evt(1, 8'h14, 8'h18, RTCF_VEC_HI, 0);
		check(tos_v, pc_cur);
		check(sp_v, sp_cur + 5'h1);
		{high_prio_global_irq_enable, low_prio_global_irq_enable, hi_prio} <= 3'b010;
		evt(1, 8'h14, 8'h18, RTCF_VEC_LO, 0);
		sleep <= 1'b0;
		fire(5, n);
		check(n, OS);
		mode <= RTCF_OSC_HS;
		pll <= 1'b1;
		fire(5, m2);
		check(m2 - n, PL);
		mode <= RTCF_OSC_EC;
		fire(5, n);
		check(n <= 3, 1);
		for (int m = 0; m < 7; m++) begin
			mode <= m[2:0];
			@(posedge clk);
			#1;
			check(bit6, m == 4 || m == 6);
		end
		tally_and_finish();
	end
endmodule // tb_rtcf_top
